/* inc/sdlmc_map.vh */
// Overview of operation
// - Auto-select pin high picks automatic detection, low picks manual selection.
// - Deserializer builds 10-bit words and feeds video and ASI aligners together.
// - Lock detection runs continuously from reset release until reset is held.
// - Without carrier, lock low and every video and select output low except pixel clock.
// - Pixel clock keeps running while unlocked; accurate only once locked.
// - Auto mode with carrier searches for timing-reference or ASI sync words.
// - Manual mode searches only for the sync type the select pins pick.
// - Lock rises only with reclocker locked and either proper sync words identified or, in manual mode, both selects low.
// - Lock indicator never toggles during acquisition nor glitches on switches.
// - Manual non-conforming input passes raw words; locked only if selects low. Code passes words only while locked; otherwise data stays low.
// - Auto non-conforming input: lock low, data low, both status outputs low.
// - Reclocker unlocked: no sync search, lock low, video and select outputs low except clock.
// - Auto mode drives select pins: video high/low, ASI low/high, none low/low.
// - Reclocker supplies PLL-lock and signal-present flags to the lock detector.
// - Processing features enabled after reset, each disableable by register.
// - Enter ASI only after 32 consecutive words without code or disparity error.
// - Leave video only after 6 consecutive expected timing words are missed.
`ifndef SDLMC_MAP_VH
`define SDLMC_MAP_VH

`define SDLMC_ADDR_CTRL       5'h00
`define SDLMC_ADDR_STATUS     5'h04
`define SDLMC_ADDR_INT_STAT   5'h08
`define SDLMC_ADDR_INT_CLR    5'h0C
`define SDLMC_ADDR_INT_EN     5'h10

`define SDLMC_CTRL_VIDEO_EN   0
`define SDLMC_CTRL_ASI_EN     1
`define SDLMC_CTRL_RESET      2'h3

`define SDLMC_INT_LOCK_GAIN   0
`define SDLMC_INT_LOCK_LOSS   1
`define SDLMC_INT_MODE_CHG    2

`define SDLMC_ST_SEARCH       2'h0
`define SDLMC_ST_VIDEO        2'h1
`define SDLMC_ST_ASI          2'h2
`define SDLMC_ST_THRU         2'h3

`define SDLMC_WORD_BITS       10
`define SDLMC_PCLK_HALF       4'h5
`define SDLMC_TRS_PATTERN     30'h000003FF
`define SDLMC_K285_NEG        10'h17C
`define SDLMC_K285_POS        10'h283
`define SDLMC_ASI_ENTER_WORDS 6'h20
`define SDLMC_ASI_LEAVE_ERRS  6'h20
`define SDLMC_TRS_MISS_MAX    3'h6
`define SDLMC_TRS_GAP_WORDS   1728

`endif

/* core/sdlmc_sync.v */
module sdlmc_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,
    input  wire             arst_n_in,
    input  wire             ce_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule

/* core/sdlmc_top.v */
// Implementation choices: the register addresses and the Avalon-MM register port.
`include "sdlmc_map.vh"

module sdlmc_top #(
    parameter TRS_GAP_WORDS = `SDLMC_TRS_GAP_WORDS
) (
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire        ce_in,
    input  wire        serial_bit_in,
    input  wire        serial_valid_in,
    input  wire        pll_lock_in,
    input  wire        carrier_detect_in,
    input  wire        auto_select_in,
    input  wire        video_select_in,
    input  wire        asi_select_in,
    output wire        video_select_out,
    output wire        video_select_oe_out,
    output wire        asi_select_out,
    output wire        asi_select_oe_out,
    output wire        locked_out,
    output wire [9:0]  data_out,
    output wire        data_valid_out,
    output wire        pclk_out,
    output wire        irq_out,
    input  wire [4:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [3:0]  avs_byteenable_in,
    input  wire [31:0] avs_writedata_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out
);
    wire [4:0] pins_sync;
    wire       pll_s;
    wire       carrier_s;
    wire       auto_s;
    wire       vsel_s;
    wire       asel_s;

    // Two-stage capture of all pins from outside this clock
    sdlmc_sync #(.WIDTH(5)) u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .ce_in     (ce_in),
        .async_in  ({pll_lock_in, carrier_detect_in, auto_select_in,
                     video_select_in, asi_select_in}),
        .sync_out  (pins_sync)
    );
    assign pll_s     = pins_sync[4];
    assign carrier_s = pins_sync[3];
    assign auto_s    = pins_sync[2];
    assign vsel_s    = pins_sync[1];
    assign asel_s    = pins_sync[0];

    reg [29:0] shift_reg;
    reg [3:0]  bit_cnt_reg;
    reg [3:0]  div_cnt_reg;
    reg [1:0]  state_reg;
    reg [5:0]  asi_run_reg;
    reg        asi_seen_reg;
    reg [5:0]  err_run_reg;
    reg        rd_pos_reg;
    reg [11:0] gap_cnt_reg;
    reg [2:0]  miss_cnt_reg;
    reg        locked_reg;
    reg [9:0]  data_reg;
    reg        data_valid_reg;
    reg        pclk_reg;
    reg        vsel_out_reg;
    reg        vsel_oe_reg;
    reg        asel_out_reg;
    reg        asel_oe_reg;
    reg [1:0]  ctrl_reg;
    reg [2:0]  int_stat_reg;
    reg [2:0]  int_en_reg;
    reg        irq_reg;
    reg [31:0] rdata_reg;
    reg        waitreq_reg;

    reg [1:0]  state_next;
    reg [5:0]  asi_run_next;
    reg        asi_seen_next;
    reg [5:0]  err_run_next;
    reg [11:0] gap_cnt_next;
    reg [2:0]  miss_cnt_next;

    wire [29:0] shift_next = {serial_bit_in, shift_reg[29:1]};
    wire [9:0]  word_now   = shift_next[29:20];
    wire        input_ok   = pll_s & carrier_s;
    wire        trs_hit    = serial_valid_in && (shift_next == `SDLMC_TRS_PATTERN);
    wire        k285_hit   = serial_valid_in &&
                             (word_now == `SDLMC_K285_NEG || word_now == `SDLMC_K285_POS);
    wire        at_bound   = (bit_cnt_reg == `SDLMC_WORD_BITS - 1);
    wire        searching  = (state_reg == `SDLMC_ST_SEARCH);
    // Realign only while searching so a locked stream is never shifted
    wire        realign    = searching && input_ok && (trs_hit || k285_hit);
    wire        word_end   = serial_valid_in && (at_bound || realign);

    // Feature enables gate which detectors may act
    wire want_video = ctrl_reg[`SDLMC_CTRL_VIDEO_EN] &
                      (auto_s | (vsel_s & ~asel_s));
    wire want_asi   = ctrl_reg[`SDLMC_CTRL_ASI_EN] & (auto_s | asel_s);
    wire want_thru  = ~auto_s & ~vsel_s & ~asel_s;

    function [3:0] ones10;
        input [9:0] w;
        integer i;
        begin
            ones10 = 4'h0;
            for (i = 0; i < 10; i = i + 1)
                ones10 = ones10 + {3'h0, w[i]};
        end
    endfunction

    wire [3:0] ones_now = ones10(word_now);
    // Code check limited to balance and running disparity
    wire       word_clean = (ones_now == 4'h5) ||
                            (ones_now == 4'h6 && !rd_pos_reg) ||
                            (ones_now == 4'h4 && rd_pos_reg);

    always @* begin
        state_next    = state_reg;
        asi_run_next  = asi_run_reg;
        asi_seen_next = asi_seen_reg;
        err_run_next  = err_run_reg;
        gap_cnt_next  = gap_cnt_reg;
        miss_cnt_next = miss_cnt_reg;
        if (!input_ok) begin
            state_next    = `SDLMC_ST_SEARCH;
            asi_run_next  = 6'h00;
            asi_seen_next = 1'b0;
            err_run_next  = 6'h00;
            gap_cnt_next  = 12'h000;
            miss_cnt_next = 3'h0;
        end else if (word_end) begin
            case (state_reg)
                `SDLMC_ST_SEARCH: begin
                    gap_cnt_next  = 12'h000;
                    miss_cnt_next = 3'h0;
                    err_run_next  = 6'h00;
                    if (want_thru) begin
                        state_next = `SDLMC_ST_THRU;
                    end else if (want_video && trs_hit) begin
                        state_next = `SDLMC_ST_VIDEO;
                    end else if (want_asi) begin
                        // Later commas in the run count as clean words, not restarts
                        if (k285_hit && !asi_seen_reg) begin
                            asi_seen_next = 1'b1;
                            asi_run_next  = 6'h01;
                        end else if (asi_seen_reg && word_clean) begin
                            asi_run_next = asi_run_reg + 6'h01;
                            if (asi_run_reg == `SDLMC_ASI_ENTER_WORDS - 6'h01)
                                state_next = `SDLMC_ST_ASI;
                        end else begin
                            asi_seen_next = 1'b0;
                            asi_run_next  = 6'h00;
                        end
                    end
                end
                `SDLMC_ST_VIDEO: begin
                    if (!want_video || want_thru) begin
                        state_next = `SDLMC_ST_SEARCH;
                    end else if (trs_hit) begin
                        gap_cnt_next  = 12'h000;
                        miss_cnt_next = 3'h0;
                    end else if (gap_cnt_reg == TRS_GAP_WORDS[11:0] - 12'h001) begin
                        gap_cnt_next  = 12'h000;
                        miss_cnt_next = miss_cnt_reg + 3'h1;
                        // A lone miss from a source switch keeps lock
                        if (miss_cnt_reg == `SDLMC_TRS_MISS_MAX - 3'h1)
                            state_next = `SDLMC_ST_SEARCH;
                    end else begin
                        gap_cnt_next = gap_cnt_reg + 12'h001;
                    end
                end
                `SDLMC_ST_ASI: begin
                    asi_run_next  = 6'h00;
                    asi_seen_next = 1'b0;
                    if (!want_asi || want_thru) begin
                        state_next = `SDLMC_ST_SEARCH;
                    end else if (trs_hit && want_video) begin
                        state_next = `SDLMC_ST_VIDEO;
                    end else if (word_clean) begin
                        err_run_next = 6'h00;
                    end else begin
                        err_run_next = err_run_reg + 6'h01;
                        if (err_run_reg == `SDLMC_ASI_LEAVE_ERRS - 6'h01)
                            state_next = `SDLMC_ST_SEARCH;
                    end
                end
                `SDLMC_ST_THRU: begin
                    if (!want_thru)
                        state_next = `SDLMC_ST_SEARCH;
                end
                default: begin
                    state_next = `SDLMC_ST_SEARCH;
                end
            endcase
        end
    end

    wire locked_next = input_ok && !searching;
    wire [2:0] events = {state_next != state_reg,
                         locked_reg && !locked_next,
                         !locked_reg && locked_next};

    // Deserializer, lock state and outputs
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_reg      <= 30'h00000000;
            bit_cnt_reg    <= 4'h0;
            div_cnt_reg    <= 4'h0;
            state_reg      <= `SDLMC_ST_SEARCH;
            asi_run_reg    <= 6'h00;
            asi_seen_reg   <= 1'b0;
            err_run_reg    <= 6'h00;
            rd_pos_reg     <= 1'b0;
            gap_cnt_reg    <= 12'h000;
            miss_cnt_reg   <= 3'h0;
            locked_reg     <= 1'b0;
            data_reg       <= 10'h000;
            data_valid_reg <= 1'b0;
            pclk_reg       <= 1'b0;
            vsel_out_reg   <= 1'b0;
            vsel_oe_reg    <= 1'b0;
            asel_out_reg   <= 1'b0;
            asel_oe_reg    <= 1'b0;
        end else if (ce_in) begin
            if (serial_valid_in) begin
                shift_reg   <= shift_next;
                bit_cnt_reg <= word_end ? 4'h0 : bit_cnt_reg + 4'h1;
            end
            if (word_end)
                rd_pos_reg <= (ones_now > 4'h5) ? 1'b1 :
                              (ones_now < 4'h5) ? 1'b0 : rd_pos_reg;
            div_cnt_reg  <= (div_cnt_reg == `SDLMC_WORD_BITS - 1) ? 4'h0 : div_cnt_reg + 4'h1;
            state_reg    <= state_next;
            asi_run_reg  <= asi_run_next;
            asi_seen_reg <= asi_seen_next;
            err_run_reg  <= err_run_next;
            gap_cnt_reg  <= gap_cnt_next;
            miss_cnt_reg <= miss_cnt_next;
            // Lock only follows the settled state, never a raw hit
            locked_reg   <= locked_next;
            // Free divider keeps the clock alive with no stream
            pclk_reg <= input_ok ? (bit_cnt_reg < `SDLMC_PCLK_HALF)
                                 : (div_cnt_reg < `SDLMC_PCLK_HALF);
            data_valid_reg <= word_end && locked_next;
            if (!locked_next)
                data_reg <= 10'h000;
            else if (word_end)
                data_reg <= word_now;
            vsel_oe_reg  <= auto_s && input_ok;
            asel_oe_reg  <= auto_s && input_ok;
            // Same state as the lock flag, so status never disagrees with it
            vsel_out_reg <= auto_s && locked_next && state_reg == `SDLMC_ST_VIDEO;
            asel_out_reg <= auto_s && locked_next && state_reg == `SDLMC_ST_ASI;
        end
    end

    // Avalon-MM slave: one wait cycle, then the access completes
    wire req      = avs_read_in || avs_write_in;
    wire accept   = req && !waitreq_reg;
    wire wr_lane0 = accept && avs_write_in && avs_byteenable_in[0];
    wire clr_hit  = wr_lane0 && avs_address_in == `SDLMC_ADDR_INT_CLR;
    wire [2:0] clr_mask = clr_hit ? avs_writedata_in[2:0] : 3'h0;
    // Set beats clear when both land together
    wire [2:0] int_stat_next = (int_stat_reg & ~clr_mask) | events;

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg     <= `SDLMC_CTRL_RESET;
            int_stat_reg <= 3'h0;
            int_en_reg   <= 3'h0;
            irq_reg      <= 1'b0;
            rdata_reg    <= 32'h00000000;
            waitreq_reg  <= 1'b1;
        end else if (ce_in) begin
            waitreq_reg  <= !(req && waitreq_reg);
            int_stat_reg <= int_stat_next;
            irq_reg      <= |(int_stat_next & int_en_reg);
            if (wr_lane0 && avs_address_in == `SDLMC_ADDR_CTRL)
                ctrl_reg <= avs_writedata_in[1:0];
            if (wr_lane0 && avs_address_in == `SDLMC_ADDR_INT_EN)
                int_en_reg <= avs_writedata_in[2:0];
            if (req && waitreq_reg && avs_read_in) begin
                case (avs_address_in)
                    `SDLMC_ADDR_CTRL:     rdata_reg <= {30'h00000000, ctrl_reg};
                    `SDLMC_ADDR_STATUS:   rdata_reg <= {26'h0000000, auto_s, carrier_s,
                                                        pll_s, locked_reg, state_reg};
                    `SDLMC_ADDR_INT_STAT: rdata_reg <= {29'h00000000, int_stat_reg};
                    `SDLMC_ADDR_INT_EN:   rdata_reg <= {29'h00000000, int_en_reg};
                    default:              rdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    assign video_select_out    = vsel_out_reg;
    assign video_select_oe_out = vsel_oe_reg;
    assign asi_select_out      = asel_out_reg;
    assign asi_select_oe_out   = asel_oe_reg;
    assign locked_out          = locked_reg;
    assign data_out            = data_reg;
    assign data_valid_out      = data_valid_reg;
    assign pclk_out            = pclk_reg;
    assign irq_out             = irq_reg;
    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = waitreq_reg;
endmodule

/* verif/sdlmc_asserts.sv */
module sdlmc_asserts (
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    input wire logic       ce_in,
    input wire logic       pll_lock_in,
    input wire logic       carrier_detect_in,
    input wire logic       auto_select_in,
    input wire logic       video_select_in,
    input wire logic       asi_select_in,
    input wire logic       video_select_out,
    input wire logic       video_select_oe_out,
    input wire logic       asi_select_out,
    input wire logic       asi_select_oe_out,
    input wire logic       locked_out,
    input wire logic [9:0] data_out,
    input wire logic       data_valid_out,
    input wire logic       avs_read_in,
    input wire logic       avs_write_in,
    input wire logic       avs_waitrequest_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // Six samples span the pin synchronizer plus state and output flops
    sequence link_down_s;
        (ce_in && !(pll_lock_in && carrier_detect_in))[*6];
    endsequence
    sequence lock_rise_s;
        $rose(locked_out) ##1 (pll_lock_in && carrier_detect_in && $stable(auto_select_in)
            && $stable(video_select_in) && $stable(asi_select_in))[*6];
    endsequence
    chk_link_down: assert property (link_down_s |-> !locked_out && !video_select_oe_out
        && !asi_select_oe_out && !video_select_out && !asi_select_out && !data_valid_out)
        else $error("outputs live while link down");
    chk_unlocked_idle: assert property (!locked_out[*2] |-> data_out == 10'h000
        && !data_valid_out) else $error("data while unlocked");
    chk_manual_noe: assert property ((ce_in && !auto_select_in)[*6] |->
        !video_select_oe_out && !asi_select_oe_out) else $error("select pins driven in manual");
    chk_auto_status: assert property (video_select_oe_out |-> asi_select_oe_out &&
        (locked_out ? (video_select_out ^ asi_select_out) : !(video_select_out || asi_select_out)))
        else $error("bad format status");
    chk_bus_wait: assert property (ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bus answer timing");
    chk_lock_cause: assert property ($rose(locked_out) |-> $past(pll_lock_in, 3)
        && $past(carrier_detect_in, 3)) else $error("lock without reclocker lock");
    chk_lock_steady: assert property (lock_rise_s |-> locked_out)
        else $error("lock toggled");
    chk_valid_pace: assert property (data_valid_out |=> !data_valid_out[*8])
        else $error("word strobes too close");
endmodule

/* verif/sdlmc_eq_model.sv */
module sdlmc_eq_model (
    input  wire logic clk_in,
    output logic      serial_bit_out,
    output logic      serial_valid_out,
    output logic      pll_lock_out,
    output logic      carrier_detect_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;
    initial begin
        serial_bit_out = 1'h0;
        serial_valid_out = 1'h0;
        pll_lock_out = 1'h0;
        carrier_detect_out = 1'h0;
    end
    task automatic link(input logic pll, input logic car);
        @(posedge clk_in);
        pll_lock_out <= pll;
        carrier_detect_out <= car;
    endtask
    // LSB first; a slow source drops valid and scrambles the idle bit
    task automatic send(input logic [9:0] w);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            serial_bit_out <= w[i];
            serial_valid_out <= 1'h1;
            repeat (gap) begin
                @(posedge clk_in);
                serial_valid_out <= 1'h0;
                serial_bit_out <= ~serial_bit_out;
            end
        end
    endtask
    task automatic idle();
        @(posedge clk_in);
        serial_valid_out <= 1'h0;
        serial_bit_out <= ~serial_bit_out;
    endtask
endmodule

/* verif/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP = 20;
    typedef struct packed {logic auto_m, vs, as; logic [1:0] kind; logic lk, vo, ao, oe;} sdlmc_row_t;
    logic        clk_in   = 1'h0;
    logic        arst_n   = 1'h0;
    logic        auto_sel = 1'h1;
    logic        vsel     = 1'h0;
    logic        asel     = 1'h0;
    logic        rd_en    = 1'h0;
    logic        wr_en    = 1'h0;
    logic [4:0]  addr     = 5'h00;
    logic [31:0] wdata    = 32'h0;
    logic [31:0] q;
    logic        p        = 1'h0;
    wire         sbit, sval, pll, car, vso, vsoe, aso, asoe, locked, dval, pclk, irq, wreq;
    wire  [9:0]  dout;
    wire  [31:0] rdata;
    int          mismatches = 0;
    int          n_compared = 0;
    int          n;
    sdlmc_row_t  rows [7] = '{
        '{1'h1, 1'h0, 1'h0, 2'h1, 1'h1, 1'h1, 1'h0, 1'h1},
        '{1'h1, 1'h0, 1'h0, 2'h2, 1'h1, 1'h0, 1'h1, 1'h1},
        '{1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1},
        '{1'h0, 1'h1, 1'h0, 2'h1, 1'h1, 1'h0, 1'h0, 1'h0},
        '{1'h0, 1'h1, 1'h1, 2'h2, 1'h1, 1'h0, 1'h0, 1'h0},
        '{1'h0, 1'h0, 1'h0, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0},
        '{1'h0, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0}};
    initial forever #20 clk_in = ~clk_in;
    sdlmc_eq_model sdlmc_eq_model_i (.clk_in(clk_in), .serial_bit_out(sbit),
        .serial_valid_out(sval), .pll_lock_out(pll), .carrier_detect_out(car));
    sdlmc_top #(.TRS_GAP_WORDS(GAP)) sdlmc_top_i (.clk_in(clk_in), .arst_n_in(arst_n),
        .ce_in(1'h1), .serial_bit_in(sbit), .serial_valid_in(sval), .pll_lock_in(pll),
        .carrier_detect_in(car), .auto_select_in(auto_sel), .video_select_in(vsel),
        .asi_select_in(asel), .video_select_out(vso), .video_select_oe_out(vsoe),
        .asi_select_out(aso), .asi_select_oe_out(asoe), .locked_out(locked), .data_out(dout),
        .data_valid_out(dval), .pclk_out(pclk), .irq_out(irq), .avs_address_in(addr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_byteenable_in(4'hF),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_en <= wr;
        rd_en <= !wr;
        do begin
            @(posedge clk_in);
        end while (wreq !== 1'h0);
        q = rdata;
        wr_en <= 1'h0;
        rd_en <= 1'h0;
    endtask
    task automatic restart(input logic [2:0] cfg);
        @(posedge clk_in);
        arst_n <= 1'h0;
        {auto_sel, vsel, asel} <= cfg;
        @(posedge clk_in);
        arst_n <= 1'h1;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic stream(input logic [1:0] kind, input int words);
        logic [9:0] w;
        for (int i = 0; i < words; i++) begin
            if (kind == 2'h1) w = (i % GAP == 0) ? 10'h3FF : ((i % GAP < 3) ? 10'h000 : 10'h200);
            else if (kind == 2'h2) w = i[0] ? 10'h283 : 10'h17C;
            else w = 10'h200;
            sdlmc_eq_model_i.send(w);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        arst_n <= 1'h1;
        sdlmc_eq_model_i.link(1'h1, 1'h1);
        foreach (rows[r]) begin
            restart({rows[r].auto_m, rows[r].vs, rows[r].as});
            stream(rows[r].kind, 60);
            @(negedge clk_in);
            cmp("locked", rows[r].lk, locked);
            cmp("video oe", rows[r].oe, vsoe);
            cmp("asi oe", rows[r].oe, asoe);
            if (rows[r].oe) cmp("format", {rows[r].vo, rows[r].ao}, {vso, aso});
            if (rows[r].kind == 2'h0 && rows[r].lk) cmp("through data", 10'h200, dout);
            sdlmc_eq_model_i.idle();
        end
        restart(3'h4);
        stream(2'h1, 45);
        sdlmc_eq_model_i.link(1'h0, 1'h1);
        stream(2'h1, 3);
        @(negedge clk_in);
        cmp("locked pll down", 1'h0, locked);
        cmp("data pll down", 10'h000, dout);
        sdlmc_eq_model_i.link(1'h1, 1'h0);
        n = 0;
        repeat (40) begin
            @(posedge clk_in);
            n += (pclk !== p);
            p = pclk;
        end
        cmp("pclk running", 1'h1, n > 4);
        cmp("locked no carrier", 1'h0, locked);
        sdlmc_eq_model_i.link(1'h1, 1'h1);
        restart(3'h4);
        stream(2'h1, 3 * GAP);
        stream(2'h0, 4 * GAP);
        @(negedge clk_in);
        cmp("locked few misses", 1'h1, locked);
        stream(2'h0, 3 * GAP);
        @(negedge clk_in);
        cmp("locked many misses", 1'h0, locked);
        restart(3'h4);
        sdlmc_eq_model_i.gap = 2;
        stream(2'h2, 30);
        @(negedge clk_in);
        cmp("asi early", 1'h0, locked);
        stream(2'h2, 4);
        @(negedge clk_in);
        cmp("asi locked", 1'h1, locked);
        sdlmc_eq_model_i.gap = 0;
        restart(3'h4);
        bus(1'h0, 5'h00, 32'h0);
        cmp("ctrl reset", 32'h3, q);
        bus(1'h0, 5'h14, 32'h0);
        cmp("unmapped", 32'h0, q);
        bus(1'h1, 5'h10, 32'h1);
        stream(2'h1, 45);
        bus(1'h0, 5'h04, 32'h0);
        cmp("status", 32'h3D, q);
        bus(1'h0, 5'h08, 32'h0);
        cmp("int stat", 32'h5, q);
        settle();
        cmp("irq set", 1'h1, irq);
        bus(1'h1, 5'h0C, 32'h7);
        settle();
        cmp("irq cleared", 1'h0, irq);
        bus(1'h1, 5'h10, 32'h2);
        sdlmc_eq_model_i.link(1'h0, 1'h1);
        settle();
        settle();
        cmp("irq loss", 1'h1, irq);
        bus(1'h1, 5'h10, 32'h0);
        settle();
        cmp("irq masked", 1'h0, irq);
        sdlmc_eq_model_i.link(1'h1, 1'h1);
        bus(1'h1, 5'h00, 32'h2);
        stream(2'h1, 45);
        @(negedge clk_in);
        cmp("video disabled", 1'h0, locked);
        summarize();
    end
endmodule

bind sdlmc_top sdlmc_asserts sdlmc_asserts_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .ce_in(ce_in), .pll_lock_in(pll_lock_in), .carrier_detect_in(carrier_detect_in),
    .auto_select_in(auto_select_in), .video_select_in(video_select_in),
    .asi_select_in(asi_select_in), .video_select_out(video_select_out),
    .video_select_oe_out(video_select_oe_out), .asi_select_out(asi_select_out),
    .asi_select_oe_out(asi_select_oe_out), .locked_out(locked_out), .data_out(data_out),
    .data_valid_out(data_valid_out), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out));
